// ==== core/acs_sequencer.sv ====
// Contract
// - byte 001xxxxx writes averaging configuration
// - averaging off: one conversion per result
// - count code selects 4, 8, 16, 32 conversions
// - repeat code gives 4..16 results, mode 10
// - byte 0001xxxx is reset, bits 2..0 ignored
// - bit3 low resets all, high flushes fifo
// - mode 00: start pulse runs whole scan
// - temperature result enters fifo first
// - end-of-conversion released by select or start
// - mode 01: fall tracks, rise converts
// - temperature timing internal, short start pulse
// - mode 01 averaging: one pulse per conversion
// - mode 01 temperature on first rising edge
// - power-up clock mode is 10
// - mode 10: conversion write runs whole scan
// - mode 10: only select releases end-of-conversion
// - modes 0x use pin, 10 uses write, 11 starts nothing
// - result shifted msb first, four zeros
`timescale 1ns/10ps
`include "acs_params.svh"
module acs_sequencer (
    input wire logic mclk, // 100 MHz system clock
    input wire logic reset, // synchronous, active high
    input wire logic cs_n, // chip select pin
    input wire logic sclk, // serial clock pin
    input wire logic din, // serial data pin
    input wire logic convert_start_n, // convert-start pin
    input wire logic adc_done, // converter result pulse
    input wire logic [11:0] adc_data, // converter result
    output logic dout, // serial data out
    output logic eoc_n, // end of conversion
    output logic adc_power, // converter powered
    output logic adc_start, // start one conversion
    output logic adc_temp, // conversion is temperature
    output logic [3:0] adc_channel // channel to convert
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    function automatic logic [5:0] avg_num(input logic [4:0] cfg);
        return cfg[`ACS_AVG_EN_BIT] ? (6'h04 << cfg[3:2]) : 6'h01;
    endfunction
    function automatic logic [2:0] avg_sh(input logic [4:0] cfg);
        return cfg[`ACS_AVG_EN_BIT] ? 3'h2 + {1'b0, cfg[3:2]} : 3'h0;
    endfunction
    function automatic logic [4:0] rep_num(input logic [1:0] c);
        return {1'b0, c, 2'b00} + 5'h04;
    endfunction

    // pins: cs_n, sclk, din, convert_start_n in bits 3..0
    logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q;
    logic [6:0] rx_sh_q, rx_sh_d;
    logic [2:0] rx_cnt_q, rx_cnt_d;
    logic [15:0] tx_sh_q, tx_sh_d;
    logic [3:0] tx_cnt_q, tx_cnt_d;
    logic dout_q, dout_d;
    logic [1:0] ck_mode_q, ck_mode_d;
    logic [4:0] avg_cfg_q, avg_cfg_d;
    logic [3:0] conv_ch_q, conv_ch_d;
    logic [1:0] scan_q, scan_d;
    logic temp_req_q, temp_req_d;
    acs_pkg::acs_state_t st_q, st_d;
    logic [3:0] cur_ch_q, cur_ch_d;
    logic temp_pend_q, temp_pend_d;
    logic [4:0] reps_left_q, reps_left_d;
    logic [5:0] avg_left_q, avg_left_d;
    logic [16:0] acc_q, acc_d;
    logic eoc_n_q, eoc_n_d;
    logic power_q, power_d;
    logic start_q, start_d;
    logic tconv_q, tconv_d;
    logic [3:0] chan_q, chan_d;
    logic [3:0] rd_ptr_q, rd_ptr_d, wr_ptr_q, wr_ptr_d;
    logic [4:0] cnt_q, cnt_d;
    logic [11:0] fifo_mem [0:15];
    logic cs_fall, sck_rise, sck_fall, cv_fall, cv_rise;
    logic byte_ok, conv_wr, flush, kill, go, last, eoc_set, push, push_ok, pop;
    logic [7:0] rx_byte;
    logic [16:0] sum;
    logic [11:0] push_dat;

    // edge finding reads only the second and third stages
    assign cs_fall = !pin_s2_q[3] && pin_s3_q[3];
    assign sck_rise = pin_s2_q[2] && !pin_s3_q[2] && !pin_s2_q[3];
    assign sck_fall = !pin_s2_q[2] && pin_s3_q[2] && !pin_s2_q[3];
    assign cv_fall = !pin_s2_q[0] && pin_s3_q[0];
    assign cv_rise = pin_s2_q[0] && !pin_s3_q[0];
    assign rx_byte = {rx_sh_q, pin_s2_q[1]};

    // serial port, decode and fifo pop request
    always_comb begin
        rx_sh_d = rx_sh_q;
        rx_cnt_d = rx_cnt_q;
        tx_sh_d = tx_sh_q;
        tx_cnt_d = tx_cnt_q;
        ck_mode_d = ck_mode_q;
        avg_cfg_d = avg_cfg_q;
        conv_ch_d = conv_ch_q;
        scan_d = scan_q;
        temp_req_d = temp_req_q;
        byte_ok = 1'b0;
        conv_wr = 1'b0;
        flush = 1'b0;
        kill = 1'b0;
        pop = 1'b0;
        // a byte counts only when all eight bits arrived inside one select
        if (cs_fall) begin
            rx_cnt_d = 3'h0;
        end else if (sck_rise) begin
            rx_sh_d = rx_byte[6:0];
            rx_cnt_d = rx_cnt_q + 3'h1;
            byte_ok = (rx_cnt_q == 3'h7);
        end
        if (byte_ok) begin
            if (rx_byte[7]) begin
                conv_ch_d = rx_byte[6:3];
                scan_d = rx_byte[2:1];
                temp_req_d = rx_byte[0];
                conv_wr = 1'b1;
            end else if (rx_byte[6]) begin
                ck_mode_d = rx_byte[5:4];
            end else if (rx_byte[5]) begin
                avg_cfg_d = rx_byte[4:0];
            end else if (rx_byte[4]) begin
                flush = 1'b1;
                if (!rx_byte[`ACS_RST_KEEP_BIT]) begin
                    ck_mode_d = `ACS_CKMODE_RST;
                    avg_cfg_d = `ACS_AVG_RST;
                    conv_ch_d = `ACS_CH_RST;
                    scan_d = `ACS_SCAN_RST;
                    temp_req_d = 1'b0;
                    kill = 1'b1;
                end
            end
        end
        // result words leave msb first, bit 15 already showing at select
        if (cs_fall) begin
            tx_sh_d = (cnt_q != 5'h00) ? {4'h0, fifo_mem[rd_ptr_q]} : 16'h0000;
            tx_cnt_d = 4'h0;
        end else if (sck_fall) begin
            tx_cnt_d = tx_cnt_q + 4'h1;
            if (tx_cnt_q == 4'hf) begin
                pop = (cnt_q != 5'h00);
                tx_sh_d = (cnt_q > 5'h01) ? {4'h0, fifo_mem[rd_ptr_q + 4'h1]} : 16'h0000;
            end else begin
                tx_sh_d = {tx_sh_q[14:0], 1'b0};
            end
        end
        dout_d = tx_sh_d[15];
    end

    // conversion sequencer
    always_comb begin
        st_d = st_q;
        cur_ch_d = cur_ch_q;
        temp_pend_d = temp_pend_q;
        reps_left_d = reps_left_q;
        avg_left_d = avg_left_q;
        acc_d = acc_q;
        power_d = power_q;
        start_d = 1'b0;
        tconv_d = tconv_q;
        chan_d = chan_q;
        go = 1'b0;
        last = 1'b0;
        eoc_set = 1'b0;
        push = 1'b0;
        push_dat = adc_data;
        sum = acc_q + {5'h00, adc_data};
        case (st_q)
            acs_pkg::ACS_IDLE: begin
                // 00 starts on the rising start edge, 10 on a conversion write
                if ((ck_mode_q == `ACS_MODE_PIN && cv_rise) ||
                    (ck_mode_q == `ACS_MODE_WRITE && conv_wr)) begin
                    go = 1'b1;
                    st_d = acs_pkg::ACS_CONV;
                end else if (ck_mode_q == `ACS_MODE_TRACK && cv_fall) begin
                    st_d = acs_pkg::ACS_TRACK;
                end
                if (st_d != acs_pkg::ACS_IDLE) begin
                    // next values: the write that starts a mode 10 scan lands in this same cycle
                    cur_ch_d = (scan_d == `ACS_SCAN_UP) ? 4'h0 : conv_ch_d;
                    temp_pend_d = temp_req_d;
                    reps_left_d = rep_num(avg_cfg_q[1:0]);
                    avg_left_d = avg_num(avg_cfg_q);
                    acc_d = 17'h00000;
                    power_d = 1'b1;
                end
            end
            acs_pkg::ACS_HOLD: begin
                // scan context kept between pulses; a new write or mode drops it
                if (conv_wr || ck_mode_q != `ACS_MODE_TRACK) begin
                    st_d = acs_pkg::ACS_IDLE;
                end else if (cv_fall) begin
                    st_d = acs_pkg::ACS_TRACK;
                    power_d = 1'b1;
                end
            end
            acs_pkg::ACS_TRACK: begin
                // temperature is timed by the converter, so a short low is enough
                if (cv_rise) begin
                    go = 1'b1;
                    st_d = acs_pkg::ACS_CONV;
                end
            end
            acs_pkg::ACS_CONV: begin
                if (adc_done) begin
                    if (tconv_q) begin
                        push = 1'b1;
                        temp_pend_d = 1'b0;
                    end else if (avg_left_q == 6'h01) begin
                        push = 1'b1;
                        push_dat = 12'(sum >> avg_sh(avg_cfg_q));
                        acc_d = 17'h00000;
                        avg_left_d = avg_num(avg_cfg_q);
                        case (scan_q)
                            `ACS_SCAN_UP: last = (cur_ch_q == conv_ch_q);
                            `ACS_SCAN_TOP: last = (cur_ch_q == `ACS_TOP_CH);
                            `ACS_SCAN_REP: last = (reps_left_q == 5'h01);
                            default: last = 1'b1;
                        endcase
                        reps_left_d = reps_left_q - 5'h01;
                        if (scan_q != `ACS_SCAN_REP) begin
                            cur_ch_d = cur_ch_q + 4'h1;
                        end
                    end else begin
                        acc_d = sum;
                        avg_left_d = avg_left_q - 6'h01;
                    end
                    // mode 01 sleeps after every conversion, others only at scan end
                    if (ck_mode_q == `ACS_MODE_TRACK || last) begin
                        power_d = 1'b0;
                        eoc_set = 1'b1;
                        st_d = last ? acs_pkg::ACS_IDLE : acs_pkg::ACS_HOLD;
                    end else begin
                        go = 1'b1;
                    end
                end
            end
            default: st_d = acs_pkg::ACS_IDLE;
        endcase
        if (go) begin
            start_d = 1'b1;
            chan_d = cur_ch_d;
            tconv_d = temp_pend_d;
        end
        if (kill) begin
            st_d = acs_pkg::ACS_IDLE;
            power_d = 1'b0;
            start_d = 1'b0;
        end
        // a scan ending in the same cycle as a release keeps the line low
        if (eoc_set) begin
            eoc_n_d = 1'b0;
        end else if (cs_fall || (!ck_mode_q[1] && cv_fall)) begin
            eoc_n_d = 1'b1;
        end else begin
            eoc_n_d = eoc_n_q;
        end
        // a full fifo drops the new result rather than the oldest
        push_ok = push && !(cnt_q == `ACS_FIFO_FULL && !pop);
        rd_ptr_d = rd_ptr_q + {3'h0, pop};
        wr_ptr_d = wr_ptr_q + {3'h0, push_ok};
        cnt_d = cnt_q + {4'h0, push_ok} - {4'h0, pop};
        if (flush) begin
            rd_ptr_d = 4'h0;
            wr_ptr_d = 4'h0;
            cnt_d = 5'h00;
        end
    end

    // registers
    always_ff @(posedge mclk) begin
        pin_s1_q <= {cs_n, sclk, din, convert_start_n};
        pin_s2_q <= pin_s1_q;
        pin_s3_q <= pin_s2_q;
        if (reset) begin
            rx_sh_q <= 7'h00;
            rx_cnt_q <= 3'h0;
            tx_sh_q <= 16'h0000;
            tx_cnt_q <= 4'h0;
            dout_q <= 1'b0;
            ck_mode_q <= `ACS_CKMODE_RST;
            avg_cfg_q <= `ACS_AVG_RST;
            conv_ch_q <= `ACS_CH_RST;
            scan_q <= `ACS_SCAN_RST;
            temp_req_q <= 1'b0;
            st_q <= acs_pkg::ACS_IDLE;
            cur_ch_q <= 4'h0;
            temp_pend_q <= 1'b0;
            reps_left_q <= 5'h00;
            avg_left_q <= 6'h01;
            acc_q <= 17'h00000;
            eoc_n_q <= 1'b1;
            power_q <= 1'b0;
            start_q <= 1'b0;
            tconv_q <= 1'b0;
            chan_q <= 4'h0;
            rd_ptr_q <= 4'h0;
            wr_ptr_q <= 4'h0;
            cnt_q <= 5'h00;
        end else begin
            rx_sh_q <= rx_sh_d;
            rx_cnt_q <= rx_cnt_d;
            tx_sh_q <= tx_sh_d;
            tx_cnt_q <= tx_cnt_d;
            dout_q <= dout_d;
            ck_mode_q <= ck_mode_d;
            avg_cfg_q <= avg_cfg_d;
            conv_ch_q <= conv_ch_d;
            scan_q <= scan_d;
            temp_req_q <= temp_req_d;
            st_q <= st_d;
            cur_ch_q <= cur_ch_d;
            temp_pend_q <= temp_pend_d;
            reps_left_q <= reps_left_d;
            avg_left_q <= avg_left_d;
            acc_q <= acc_d;
            eoc_n_q <= eoc_n_d;
            power_q <= power_d;
            start_q <= start_d;
            tconv_q <= tconv_d;
            chan_q <= chan_d;
            rd_ptr_q <= rd_ptr_d;
            wr_ptr_q <= wr_ptr_d;
            cnt_q <= cnt_d;
        end
    end

    // result storage
    always_ff @(posedge mclk) begin
        if (push_ok) begin
            fifo_mem[wr_ptr_q] <= push_dat;
        end
    end

    assign dout = dout_q;
    assign eoc_n = eoc_n_q;
    assign adc_power = power_q;
    assign adc_start = start_q;
    assign adc_temp = tconv_q;
    assign adc_channel = chan_q;

    a_avg_decode: assert property (byte_ok && rx_byte[7:5] == 3'b001 |=> avg_cfg_q == $past(rx_byte[4:0]))
        else $error("averaging byte not stored");
    a_single_conv: assert property (st_q == acs_pkg::ACS_CONV && adc_done && !tconv_q && !avg_cfg_q[4] |-> push)
        else $error("averaging off but no result pushed");
    a_avg_count: assert property (push && !tconv_q && avg_cfg_q[4] |-> avg_left_q == 6'h01 && !kill)
        else $error("average pushed before count reached");
    a_repeat_len: assert property (st_q != acs_pkg::ACS_IDLE && scan_q == `ACS_SCAN_REP
        |-> reps_left_q != 5'h00 && reps_left_q <= rep_num(avg_cfg_q[1:0]))
        else $error("repeat count out of range");
    a_flush_fifo: assert property (byte_ok && rx_byte[7:4] == 4'h1 |=> cnt_q == 5'h00)
        else $error("reset byte left fifo filled");
    a_full_reset: assert property (byte_ok && rx_byte[7:3] == 5'h02
        |=> ck_mode_q == `ACS_CKMODE_RST && avg_cfg_q == `ACS_AVG_RST && st_q == acs_pkg::ACS_IDLE)
        else $error("full reset missed configuration");
    a_keep_config: assert property (byte_ok && rx_byte[7:3] == 5'h03 |=> $stable(ck_mode_q) && $stable(avg_cfg_q))
        else $error("fifo-only reset changed configuration");
    a_eoc_powerdown: assert property ($fell(eoc_n_q) |-> !power_q && !start_q)
        else $error("end of conversion while powered");
    a_temp_first: assert property (start_q |-> tconv_q == temp_pend_q)
        else $error("channel converted before temperature");
    a_eoc_release: assert property (cs_fall && !eoc_set |=> eoc_n_q)
        else $error("select did not release end of conversion");
    a_eoc_hold10: assert property (ck_mode_q == `ACS_MODE_WRITE && !eoc_n_q && !cs_fall |=> !eoc_n_q)
        else $error("end of conversion released without select");
    a_default_mode: assert property ($fell(reset) |-> ck_mode_q == `ACS_CKMODE_RST)
        else $error("power-up clock mode wrong");
endmodule // acs_sequencer

// ==== core/acs_params.svh ====
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// clock modes
`define ACS_MODE_PIN 2'b00
`define ACS_MODE_TRACK 2'b01
`define ACS_MODE_WRITE 2'b10
// power-up defaults
`define ACS_CKMODE_RST 2'b10
`define ACS_AVG_RST 5'h00
`define ACS_CH_RST 4'h0
`define ACS_SCAN_RST 2'b00
// scan modes of the conversion byte
`define ACS_SCAN_UP 2'b00
`define ACS_SCAN_TOP 2'b01
`define ACS_SCAN_REP 2'b10
`define ACS_TOP_CH 4'hf
// control byte fields
`define ACS_AVG_EN_BIT 4
`define ACS_RST_KEEP_BIT 3
// result fifo
`define ACS_FIFO_FULL 5'h10

`endif

// ==== core/acs_pkg.sv ====
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_TRACK = 2'b01,
        ACS_CONV = 2'b10,
        ACS_HOLD = 2'b11
    } acs_state_t;
endpackage

// ==== testbench/acs_host_model.sv ====
`timescale 1ns/10ps
// host side: serial frames and convert-start pulses, all changed at the falling mclk edge
module acs_host_model (
    input wire logic mclk, // system clock
    input wire logic dout, // serial data from the device
    output logic cs_n, // chip select, idles high
    output logic sclk, // serial clock, still and low outside frames
    output logic din, // serial data to the device
    output logic convert_start_n // convert-start, idles high
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b1;
        convert_start_n = 1'b1;
    end

    // half of the 160 ns serial clock period
    task automatic half_bit();
        repeat (8) @(negedge mclk);
    endtask

    // msb-first frame; din is inverted after it so a stale level never passes for data
    task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge mclk);
        cs_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            din = tx[i];
            half_bit();
            sclk = 1'b1;
            rx[i] = dout;
            half_bit();
            sclk = 1'b0;
        end
        half_bit();
        cs_n = 1'b1;
        din = ~din;
    endtask

    task automatic write_byte(input logic [7:0] b);
        logic [15:0] unused;
        frame({8'h00, b}, 8, unused);
    endtask

    // zero bytes shifted in meanwhile decode as nothing
    task automatic read_word(output logic [15:0] w);
        frame(16'h0000, 16, w);
    endtask

    task automatic drive_start(input logic v);
        @(negedge mclk);
        convert_start_n = v;
    endtask

    // low time is given in mclk cycles; 4 cycles meet the 40 ns minimum
    task automatic start_pulse(input int n);
        drive_start(1'b0);
        repeat (n) @(negedge mclk);
        convert_start_n = 1'b1;
    endtask
endmodule // acs_host_model

// ==== testbench/acs_sequencer_tb.sv ====
`timescale 1ns/10ps
module acs_sequencer_tb;
    logic mclk;
    logic reset;
    logic cs_n, sclk, din, convert_start_n;
    logic adc_done;
    logic [11:0] adc_data;
    logic ch_step; // scan modes that step the channel per result
    logic dout, eoc_n, adc_power, adc_start, adc_temp;
    logic [3:0] adc_channel;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [15:0] rnd = 16'h54e4;
    logic [15:0] cnv_rnd = 16'h54e4;
    logic [2:0] cnv_wait = 3'h0;
    logic [16:0] conv_q[$]; // temp flag, channel and code of each conversion
    logic [3:0] ch;
    logic [15:0] w;
    int c;

    acs_sequencer i_acs_sequencer (.mclk(mclk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .din(din),
        .convert_start_n(convert_start_n), .adc_done(adc_done), .adc_data(adc_data), .dout(dout),
        .eoc_n(eoc_n), .adc_power(adc_power), .adc_start(adc_start), .adc_temp(adc_temp),
        .adc_channel(adc_channel));
    acs_host_model i_acs_host_model (.mclk(mclk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din),
        .convert_start_n(convert_start_n));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // converter stand-in: answers each start after 2 to 5 cycles, so latency is never assumed
    always @(negedge mclk) begin
        adc_done <= (cnv_wait == 3'h1) && !reset;
        if (reset) begin
            cnv_wait <= 3'h0;
            adc_data <= 12'h000;
        end else if (adc_start === 1'b1) begin
            cnv_wait <= 3'h2 + {1'b0, cnv_rnd[1:0]};
        end else if (cnv_wait == 3'h1) begin
            adc_data <= cnv_rnd[11:0];
            conv_q.push_back({adc_temp, adc_channel, cnv_rnd[11:0]});
            cnv_rnd <= lfsr(cnv_rnd);
            cnv_wait <= 3'h0;
        end else if (cnv_wait != 3'h0) begin
            cnv_wait <= cnv_wait - 3'h1;
        end
    end

    task automatic complete_run();
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // a hang is cut short well beyond the expected run of about 21500 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic check1(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check16(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_eoc();
        int n;
        n = 0;
        while (eoc_n !== 1'b0 && n < 4000) begin
            @(negedge mclk);
            n++;
        end
        check1("eoc_n low", 1'b0, eoc_n);
        check1("adc_power off", 1'b0, adc_power);
    endtask

    // reads every fifo entry of nscan scans and compares with the recorded conversions
    task automatic check_scan(input logic temp, input int nres, input int navg, input int nscan);
        int k;
        logic [16:0] sum;
        k = 0;
        check16("conversions", 16'(nscan * (nres * navg + int'(temp))), 16'(conv_q.size()));
        for (int s = 0; s < nscan; s++) begin
            if (temp) begin
                check1("temperature first", 1'b1, conv_q[k][16]);
                i_acs_host_model.read_word(w);
                check16("temperature word", {4'h0, conv_q[k][11:0]}, w);
                k++;
            end
            for (int r = 0; r < nres; r++) begin
                sum = 17'h00000;
                for (int j = 0; j < navg; j++) begin
                    check16("channel", {12'h000, ch + (ch_step ? 4'(r) : 4'h0)}, {12'h000, conv_q[k][15:12]});
                    sum = sum + {5'h00, conv_q[k][11:0]};
                    k++;
                end
                i_acs_host_model.read_word(w);
                check16("result word", {4'h0, 12'(sum >> $clog2(navg))}, w);
            end
        end
        check1("eoc_n released", 1'b1, eoc_n);
    endtask

    initial begin
        ch_step = 1'b0;
        reset = 1'b1;
        repeat (12) @(negedge mclk);
        reset = 1'b0;
        check1("eoc_n after reset", 1'b1, eoc_n);
        check1("adc_power after reset", 1'b0, adc_power);
        // power-up mode: the write alone runs the scan and the pin cannot release eoc
        ch = rnd[3:0];
        conv_q.delete();
        i_acs_host_model.write_byte({1'b1, ch, 2'b11, 1'b1});
        wait_eoc();
        i_acs_host_model.start_pulse(4);
        repeat (8) @(negedge mclk);
        check1("eoc_n holds", 1'b0, eoc_n);
        check_scan(1'b1, 1, 1, 1);
        // every average count, random filler in the repeat field
        for (c = 0; c < 4; c++) begin
            rnd = lfsr(rnd);
            ch = rnd[7:4];
            conv_q.delete();
            i_acs_host_model.write_byte({3'b001, 1'b1, c[1:0], rnd[1:0]});
            i_acs_host_model.write_byte({1'b1, ch, 2'b11, 1'b0});
            wait_eoc();
            check_scan(1'b0, 1, 4 << c, 1);
        end
        // averaging off ignores the count field; the repeat field sets the result count
        for (c = 0; c < 4; c++) begin
            rnd = lfsr(rnd);
            ch = rnd[7:4];
            conv_q.delete();
            i_acs_host_model.write_byte({3'b001, 1'b0, rnd[3:2], c[1:0]});
            i_acs_host_model.write_byte({1'b1, ch, 2'b10, 1'b0});
            wait_eoc();
            check_scan(1'b0, 4 * (c + 1), 1, 1);
        end
        // fifo-only reset keeps averaging; full reset restores the power-up state
        rnd = lfsr(rnd);
        i_acs_host_model.write_byte(8'h30);
        i_acs_host_model.write_byte({1'b1, ch, 2'b10, 1'b0});
        wait_eoc();
        i_acs_host_model.write_byte({5'b00011, rnd[2:0]});
        i_acs_host_model.read_word(w);
        check16("flushed fifo", 16'h0000, w);
        conv_q.delete();
        i_acs_host_model.write_byte({1'b1, ch, 2'b11, 1'b0});
        wait_eoc();
        check_scan(1'b0, 1, 4, 1);
        i_acs_host_model.write_byte(8'h40);
        i_acs_host_model.write_byte({5'b00010, rnd[5:3]});
        conv_q.delete();
        i_acs_host_model.write_byte({1'b1, ch, 2'b11, 1'b0});
        wait_eoc();
        check_scan(1'b0, 1, 1, 1);
        // scan upward from channel 0 to n, then from n to the top channel
        rnd = lfsr(rnd);
        ch_step = 1'b1;
        ch = 4'h0;
        conv_q.delete();
        i_acs_host_model.write_byte({1'b1, rnd[3:0], 2'b00, 1'b0});
        wait_eoc();
        check_scan(1'b0, int'(rnd[3:0]) + 1, 1, 1);
        ch = rnd[7:4];
        conv_q.delete();
        i_acs_host_model.write_byte({1'b1, ch, 2'b01, 1'b0});
        wait_eoc();
        check_scan(1'b0, 16 - int'(ch), 1, 1);
        ch_step = 1'b0;
        // pin mode: the write only configures, a short low pulse runs the scan
        i_acs_host_model.write_byte(8'h40);
        conv_q.delete();
        i_acs_host_model.write_byte({1'b1, ch, 2'b11, 1'b1});
        repeat (40) @(negedge mclk);
        check16("write starts nothing", 16'h0000, 16'(conv_q.size()));
        i_acs_host_model.start_pulse(4);
        wait_eoc();
        i_acs_host_model.start_pulse(6);
        check1("eoc_n released by start", 1'b1, eoc_n);
        wait_eoc();
        check_scan(1'b1, 1, 1, 2);
        // tracking mode: temperature on the first rise, then one pulse per averaged conversion
        i_acs_host_model.write_byte(8'h50);
        i_acs_host_model.write_byte(8'h30);
        conv_q.delete();
        i_acs_host_model.write_byte({1'b1, ch, 2'b11, 1'b1});
        i_acs_host_model.start_pulse(4);
        wait_eoc();
        check_scan(1'b1, 0, 1, 1);
        conv_q.delete();
        for (c = 0; c < 4; c++) begin
            i_acs_host_model.drive_start(1'b0);
            repeat (6) @(negedge mclk);
            check1("powered while tracking", 1'b1, adc_power);
            repeat (134) @(negedge mclk);
            i_acs_host_model.drive_start(1'b1);
            wait_eoc();
        end
        check_scan(1'b0, 1, 4, 1);
        complete_run();
    end
endmodule // acs_sequencer_tb
